// File: rtl/adc_trigger_command_control.sv
// converter control: AXI4-Lite registers, trigger select, command queue,
// result formatting and DMA requests around one sar_engine
// assumes analog pins and comparator are asynchronous, timer lines are not
`timescale 1ns/10ps
module adc_trigger_command_control (
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  input wire logic [adc_ctrl_pkg::ADDR_W-1:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [adc_ctrl_pkg::DATA_W-1:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [adc_ctrl_pkg::ADDR_W-1:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [adc_ctrl_pkg::DATA_W-1:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire logic [adc_ctrl_pkg::NUM_CH-1:0] an_pin_in,
  input wire logic timer_trigger_line_0_in,
  input wire logic timer_trigger_line_1_in,
  input wire logic cmp_in,
  output logic [3:0] channel_sel_out,
  output logic sample_out,
  output logic [adc_ctrl_pkg::RAW_W-1:0] dac_code_out,
  output logic analog_enable_out,
  output logic conv_clk_en_out,
  output logic result_dma_req_out,
  output logic cmd_dma_req_out,
  output logic conv_irq_out
);
  import adc_ctrl_pkg::*;

  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    logic [4:0] i;
    i = a[6:2];
    if (a[1:0] != 2'h0) begin
      return 1'b0;
    end else if (i <= IDX_MODE || i == IDX_INT || i == IDX_FLAG) begin
      return 1'b1;
    end else if (i == IDX_CW_HI || i == IDX_CW_LO) begin
      return 1'b1;
    end else if (i == IDX_RES_HI || i == IDX_RES_LO) begin
      return 1'b1;
    end else begin
      return 1'b0;
    end
  endfunction

  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [15:0] d,
                                          input logic [1:0] s);
    logic [15:0] m;
    m = {{8{s[1]}}, {8{s[0]}}};
    return (old & ~m) | (d & m);
  endfunction

  function automatic logic [15:0] fmt_result(input logic [9:0] r,
                                             input logic res10,
                                             input logic left,
                                             input logic sgn);
    logic [15:0] o;
    if (left) begin
      o = res10 ? {r, 6'h00} : {r[7:0], 8'h00};
      o[15] = o[15] ^ sgn;
    end else if (sgn) begin
      o = res10 ? {{7{~r[9]}}, r[8:0]} : {{9{~r[7]}}, r[6:0]};
    end else begin
      o = res10 ? {6'h00, r} : {8'h00, r[7:0]};
    end
    return o;
  endfunction

  // synchronisers for pin inputs
  logic [NUM_CH-1:0] pin_s1;
  logic [NUM_CH-1:0] pin_s2;
  logic cmp_s1;
  logic cmp_s2;

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
      cmp_s1 <= 1'b0;
      cmp_s2 <= 1'b0;
    end else begin
      pin_s1 <= an_pin_in;
      pin_s2 <= pin_s1;
      cmp_s1 <= cmp_in;
      cmp_s2 <= cmp_s1;
    end
  end

  // bus write channel
  logic aw_hold;
  logic w_hold;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [15:0] w_data_q;
  logic [1:0] w_strb_q;
  logic wr_fire;
  logic [4:0] wr_idx;

  assign wr_fire = aw_hold && w_hold && !s_axi_bvalid_out;
  assign wr_idx = aw_addr_q[6:2];

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s_axi_awready_out <= 1'b1;
      s_axi_wready_out <= 1'b1;
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out <= RESP_OKAY;
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_addr_q <= '0;
      w_data_q <= '0;
      w_strb_q <= '0;
    end else begin
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        aw_hold <= 1'b1;
        aw_addr_q <= s_axi_awaddr_in;
        s_axi_awready_out <= 1'b0;
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        w_hold <= 1'b1;
        w_data_q <= s_axi_wdata_in[15:0];
        w_strb_q <= s_axi_wstrb_in[1:0];
        s_axi_wready_out <= 1'b0;
      end
      if (wr_fire) begin
        aw_hold <= 1'b0;
        w_hold <= 1'b0;
        s_axi_bvalid_out <= 1'b1;
        s_axi_bresp_out <= is_mapped(aw_addr_q) ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_bvalid_out && s_axi_bready_in) begin
        s_axi_bvalid_out <= 1'b0;
        s_axi_awready_out <= 1'b1;
        s_axi_wready_out <= 1'b1;
      end
    end
  end

  // software-visible configuration
  logic [3:0] trig_ctl;
  logic [3:0] trig_chan;
  logic [7:0] presc;
  logic [4:0] mode_r;
  logic int_en;
  logic trig_wr;
  logic cw_wr;
  logic flag_wr;

  assign trig_wr = wr_fire && aw_addr_q[1:0] == 2'h0 && wr_idx == IDX_TRIG_CTL;
  assign cw_wr = wr_fire && aw_addr_q[1:0] == 2'h0 && wr_idx == IDX_CW_HI;
  assign flag_wr = wr_fire && aw_addr_q[1:0] == 2'h0 && wr_idx == IDX_FLAG;

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      trig_ctl <= '0;
      trig_chan <= '0;
      presc <= PRESC_RESET;
      mode_r <= MODE_RESET;
      int_en <= 1'b0;
    end else if (wr_fire && aw_addr_q[1:0] == 2'h0) begin
      // registers stay writable while disabled
      if (wr_idx == IDX_TRIG_CTL) begin
        trig_ctl <= 4'(merge16({12'h000, trig_ctl}, w_data_q, w_strb_q));
      end else if (wr_idx == IDX_TRIG_CHAN) begin
        trig_chan <= 4'(merge16({12'h000, trig_chan}, w_data_q, w_strb_q));
      end else if (wr_idx == IDX_PRESCALE) begin
        presc <= 8'(merge16({8'h00, presc}, w_data_q, w_strb_q));
      end else if (wr_idx == IDX_MODE) begin
        mode_r <= 5'(merge16({11'h000, mode_r}, w_data_q, w_strb_q));
      end else if (wr_idx == IDX_INT && w_strb_q[0]) begin
        int_en <= w_data_q[0];
      end
    end
  end

  // trigger selection and detection
  logic [1:0] src;
  logic level_mode;
  logic trig_sel;
  logic trig_act;
  logic trig_prev;
  logic trig_edge;
  logic trig_fire;

  assign src = trig_ctl[TC_SRC +: 2];
  assign level_mode = trig_ctl[TC_LEVEL];

  // timer lines are single-clock pulses from reloading counters
  always_comb begin
    case (src)
      SRC_PIN: trig_sel = pin_s2[trig_chan];
      SRC_TMR0: trig_sel = timer_trigger_line_0_in;
      SRC_TMR1: trig_sel = timer_trigger_line_1_in;
      default: trig_sel = 1'b0;
    endcase
  end

  assign trig_act = (src != SRC_NONE) && (trig_sel ^ trig_ctl[TC_INVERT]);
  assign trig_edge = trig_act && !trig_prev;
  assign trig_fire = level_mode ? trig_act : trig_edge;

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      trig_prev <= 1'b0;
    end else begin
      trig_prev <= trig_act;
    end
  end

  // command sequencing
  state_t state;
  state_t next_state;
  logic [15:0] cw_pend;
  logic [15:0] cw_act;
  logic [15:0] cmd_sel;
  logic cw_valid;
  logic mod_dis;
  logic act_wait;
  logic act_cont;
  logic pend_wait;
  logic level_abort;
  logic kill;
  logic consume;
  logic eng_start;
  logic eng_busy;
  logic eng_done;
  logic [RAW_W-1:0] eng_code;
  logic ovr_set;

  assign mod_dis = mode_r[MODE_DIS];
  assign act_wait = cw_act[CW_WAIT +: 2] == WAIT_TRIG;
  assign act_cont = cw_act[CW_SMODE +: 2] == SMODE_CONT;
  assign pend_wait = cw_pend[CW_WAIT +: 2] == WAIT_TRIG;
  assign cmd_sel = (state == st_idle) ? cw_pend : cw_act;
  // level trigger dropping mid-conversion stops it
  assign level_abort = state == st_conv && level_mode && act_wait &&
                       !trig_act;
  assign kill = trig_wr || level_abort || mod_dis;
  assign consume = state == st_idle && cw_valid && !kill;
  assign ovr_set = state == st_conv && !level_mode && trig_edge;

  always_comb begin
    next_state = state;
    eng_start = 1'b0;
    if (kill) begin
      next_state = st_idle;
    end else begin
      case (state)
        st_idle: begin
          if (cw_valid) begin
            next_state = pend_wait ? st_wait : st_conv;
            eng_start = !pend_wait;
          end
        end
        st_wait: begin
          // a still-high level starts the next word at once
          if (trig_fire) begin
            next_state = st_conv;
            eng_start = 1'b1;
          end
        end
        st_conv: begin
          if (eng_done) begin
            // continuous mode repeats until a new word arrives
            if (act_cont && !cw_valid) begin
              next_state = act_wait ? st_wait : st_conv;
              eng_start = !act_wait;
            end else begin
              next_state = st_idle;
            end
          end
        end
        default: next_state = st_idle;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state <= st_idle;
      cw_act <= '0;
      channel_sel_out <= '0;
    end else begin
      state <= next_state;
      if (consume) begin
        cw_act <= cw_pend;
      end
      if (eng_start) begin
        channel_sel_out <= cmd_sel[CW_CH +: 4];
      end
    end
  end

  sar_engine u_sar (
    .sys_clk_in(sys_clk_in),
    .rst_b_in(rst_b_in),
    .start_in(eng_start),
    .abort_in(kill),
    .res10_in(cmd_sel[CW_RES10]),
    .sample_len_in(9'(presc) + 9'(cmd_sel[CW_STIME +: 4])),
    .cmp_in(cmp_s2),
    .busy_out(eng_busy),
    .done_out(eng_done),
    .sample_out(sample_out),
    .code_out(dac_code_out)
  );

  assign eng_code = dac_code_out;

  // results, flags and DMA requests
  logic [RAW_W-1:0] result_r;
  logic res_pend;
  logic dma_block;
  logic [2:0] flags;
  logic next_cw_valid;
  logic next_res_pend;
  logic next_dma_block;
  logic [2:0] next_flags;
  logic res_rd;
  logic [2:0] flag_set;
  logic [2:0] flag_clr;

  assign res_rd = s_axi_arvalid_in && s_axi_arready_out &&
                  s_axi_araddr_in == {IDX_RES_HI, 2'h0};
  assign flag_set = {level_abort, ovr_set, eng_done};
  assign flag_clr = (flag_wr && w_strb_q[0]) ? w_data_q[2:0] : 3'h0;

  always_comb begin
    // new events win over clears
    next_flags = (flags & ~flag_clr) | flag_set;
    next_cw_valid = cw_valid;
    if (cw_wr) begin
      next_cw_valid = 1'b1;
    end else if (trig_wr || consume) begin
      next_cw_valid = 1'b0;
    end
    next_res_pend = res_pend;
    if (eng_done) begin
      next_res_pend = 1'b1;
    end else if (res_rd) begin
      next_res_pend = 1'b0;
    end
    next_dma_block = dma_block;
    if (cw_wr) begin
      next_dma_block = 1'b0;
    end else if (trig_wr || level_abort) begin
      next_dma_block = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cw_pend <= '0;
      cw_valid <= 1'b0;
      result_r <= '0;
      res_pend <= 1'b0;
      dma_block <= 1'b0;
      flags <= '0;
      result_dma_req_out <= 1'b0;
      cmd_dma_req_out <= 1'b0;
      conv_irq_out <= 1'b0;
      analog_enable_out <= 1'b0;
      conv_clk_en_out <= 1'b0;
    end else begin
      if (cw_wr) begin
        cw_pend <= merge16(cw_pend, w_data_q, w_strb_q);
      end
      if (eng_done) begin
        result_r <= eng_code;
      end
      cw_valid <= next_cw_valid;
      res_pend <= next_res_pend;
      dma_block <= next_dma_block;
      flags <= next_flags;
      result_dma_req_out <= mode_r[MODE_RES_DMA] && next_res_pend &&
                            !next_dma_block;
      cmd_dma_req_out <= mode_r[MODE_CMD_DMA] && !next_cw_valid &&
                         !next_dma_block && !mod_dis;
      conv_irq_out <= int_en && next_flags[FLAG_DONE];
      analog_enable_out <= !mod_dis;
      conv_clk_en_out <= !mod_dis;
    end
  end

  // bus read channel
  logic [15:0] rd_word;
  logic [4:0] rd_idx;

  assign rd_idx = s_axi_araddr_in[6:2];

  always_comb begin
    rd_word = 16'h0000;
    if (s_axi_araddr_in[1:0] != 2'h0) begin
      rd_word = 16'h0000;
    end else if (rd_idx == IDX_TRIG_CTL) begin
      rd_word = {12'h000, trig_ctl};
    end else if (rd_idx == IDX_TRIG_CHAN) begin
      rd_word = {12'h000, trig_chan};
    end else if (rd_idx == IDX_PRESCALE) begin
      rd_word = {8'h00, presc};
    end else if (rd_idx == IDX_MODE) begin
      rd_word = {11'h000, mode_r};
    end else if (rd_idx == IDX_INT) begin
      rd_word = {15'h0000, int_en};
    end else if (rd_idx == IDX_FLAG) begin
      rd_word = {11'h000, state != st_idle, cw_valid, flags};
    end else if (rd_idx == IDX_CW_HI) begin
      rd_word = cw_pend;
    end else if (rd_idx == IDX_CW_LO) begin
      rd_word = cw_act;
    end else if (rd_idx == IDX_RES_HI) begin
      rd_word = fmt_result(result_r, cw_act[CW_RES10],
                           mode_r[MODE_LEFT], mode_r[MODE_SIGNED]);
    end else if (rd_idx == IDX_RES_LO) begin
      rd_word = {6'h00, result_r};
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s_axi_arready_out <= 1'b1;
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out <= '0;
      s_axi_rresp_out <= RESP_OKAY;
    end else begin
      if (s_axi_arvalid_in && s_axi_arready_out) begin
        s_axi_arready_out <= 1'b0;
        s_axi_rvalid_out <= 1'b1;
        s_axi_rdata_out <= {16'h0000, rd_word};
        s_axi_rresp_out <= is_mapped(s_axi_araddr_in) ? RESP_OKAY
                                                      : RESP_SLVERR;
      end
      if (s_axi_rvalid_out && s_axi_rready_in) begin
        s_axi_rvalid_out <= 1'b0;
        s_axi_arready_out <= 1'b1;
      end
    end
  end
endmodule

// File: pkg/adc_ctrl_pkg.sv
// constants, field layouts and types of the converter control block
// assumes one 100 MHz system clock and an AXI4-Lite register port
package adc_ctrl_pkg;
  localparam int unsigned ADDR_W = 7;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned NUM_CH = 16;
  localparam int unsigned RAW_W = 10;
  // register indices; byte address is four times the index
  localparam logic [4:0] IDX_TRIG_CTL = 5'h00;
  localparam logic [4:0] IDX_TRIG_CHAN = 5'h01;
  localparam logic [4:0] IDX_PRESCALE = 5'h02;
  localparam logic [4:0] IDX_MODE = 5'h03;
  localparam logic [4:0] IDX_INT = 5'h0e;
  localparam logic [4:0] IDX_FLAG = 5'h0f;
  localparam logic [4:0] IDX_CW_HI = 5'h10;
  localparam logic [4:0] IDX_CW_LO = 5'h12;
  localparam logic [4:0] IDX_RES_HI = 5'h14;
  localparam logic [4:0] IDX_RES_LO = 5'h16;
  // trigger control fields
  localparam int unsigned TC_SRC = 0;
  localparam int unsigned TC_LEVEL = 2;
  localparam int unsigned TC_INVERT = 3;
  localparam logic [1:0] SRC_NONE = 2'h0;
  localparam logic [1:0] SRC_PIN = 2'h1;
  localparam logic [1:0] SRC_TMR0 = 2'h2;
  localparam logic [1:0] SRC_TMR1 = 2'h3;
  // operating mode fields
  localparam int unsigned MODE_DIS = 0;
  localparam int unsigned MODE_RES_DMA = 1;
  localparam int unsigned MODE_CMD_DMA = 2;
  localparam int unsigned MODE_LEFT = 3;
  localparam int unsigned MODE_SIGNED = 4;
  localparam logic [4:0] MODE_RESET = 5'h01;
  localparam logic [7:0] PRESC_RESET = 8'h04;
  // flag and status fields
  localparam int unsigned FLAG_DONE = 0;
  localparam int unsigned FLAG_OVR = 1;
  localparam int unsigned FLAG_LVL = 2;
  localparam int unsigned STAT_CW_PEND = 3;
  localparam int unsigned STAT_BUSY = 4;
  // command word fields
  localparam int unsigned CW_CH = 0;
  localparam int unsigned CW_RES10 = 4;
  localparam int unsigned CW_WAIT = 5;
  localparam int unsigned CW_SMODE = 7;
  localparam int unsigned CW_STIME = 12;
  localparam logic [1:0] WAIT_NOW = 2'h0;
  localparam logic [1:0] WAIT_TRIG = 2'h1;
  localparam logic [1:0] SMODE_PAUSE = 2'h0;
  localparam logic [1:0] SMODE_CONT = 2'h1;
  // successive approximation timing and bus responses
  localparam logic [3:0] MSB_10 = 4'h9;
  localparam logic [3:0] MSB_8 = 4'h7;
  localparam logic [1:0] SETTLE_CYCLES = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_wait = 2'b01,
    st_conv = 2'b11
  } state_t;
endpackage

// File: rtl/sar_engine.sv
// successive-approximation sequencer: sample phase, then one bit a step
// assumes the comparator input is already synchronised by the caller
`timescale 1ns/10ps
module sar_engine (
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  input wire logic start_in,
  input wire logic abort_in,
  input wire logic res10_in,
  input wire logic [8:0] sample_len_in,
  input wire logic cmp_in,
  output logic busy_out,
  output logic done_out,
  output logic sample_out,
  output logic [adc_ctrl_pkg::RAW_W-1:0] code_out
);
  import adc_ctrl_pkg::*;

  logic [8:0] cnt;
  logic [3:0] bitpos;
  logic [1:0] settle;

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      busy_out <= 1'b0;
      done_out <= 1'b0;
      sample_out <= 1'b0;
      code_out <= '0;
      cnt <= '0;
      bitpos <= '0;
      settle <= '0;
    end else if (abort_in) begin
      busy_out <= 1'b0;
      done_out <= 1'b0;
      sample_out <= 1'b0;
      code_out <= '0;
    end else begin
      done_out <= 1'b0;
      if (start_in && !busy_out) begin
        busy_out <= 1'b1;
        sample_out <= 1'b1;
        cnt <= sample_len_in;
        code_out <= '0;
        bitpos <= res10_in ? MSB_10 : MSB_8;
      end else if (busy_out && sample_out) begin
        if (cnt == 9'h000) begin
          sample_out <= 1'b0;
          code_out[bitpos] <= 1'b1;
          settle <= SETTLE_CYCLES;
        end else begin
          cnt <= cnt - 9'h001;
        end
      end else if (busy_out) begin
        if (settle != 2'h0) begin
          settle <= settle - 2'h1;
        end else begin
          // comparator low means the trial bit overshot
          if (!cmp_in) begin
            code_out[bitpos] <= 1'b0;
          end
          if (bitpos == 4'h0) begin
            busy_out <= 1'b0;
            done_out <= 1'b1;
          end else begin
            bitpos <= bitpos - 4'h1;
            code_out[bitpos - 4'h1] <= 1'b1;
            settle <= SETTLE_CYCLES;
          end
        end
      end
    end
  end
endmodule

// File: bench/adc_ctrl_chk.sv
// port checker for the converter control block
// assumes binding to the top module, one clock, async active-low reset
`timescale 1ns/10ps
module adc_ctrl_chk (
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  input wire logic s_axi_awvalid_in,
  input wire logic s_axi_awready_out,
  input wire logic s_axi_wvalid_in,
  input wire logic s_axi_wready_out,
  input wire logic s_axi_bvalid_out,
  input wire logic [adc_ctrl_pkg::ADDR_W-1:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  input wire logic s_axi_arready_out,
  input wire logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire logic sample_out,
  input wire logic [3:0] channel_sel_out,
  input wire logic analog_enable_out,
  input wire logic conv_clk_en_out,
  input wire logic cmd_dma_req_out,
  input wire logic result_dma_req_out
);
  import adc_ctrl_pkg::*;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_b_in);
  a_clk_en: assert property (conv_clk_en_out == analog_enable_out)
    else $error("clock enable differs from analog enable");
  a_off_no_cmd: assert property (
    !analog_enable_out |-> !cmd_dma_req_out)
    else $error("command request while disabled");
  a_sample_en: assert property (
    $rose(sample_out) |-> analog_enable_out)
    else $error("sampling while disabled");
  a_chan_hold: assert property (
    sample_out ##1 sample_out |-> $stable(channel_sel_out))
    else $error("channel changed while sampling");
  a_rd_answer: assert property (
    s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
    else $error("read answer late");
  a_rd_busy: assert property (
    s_axi_rvalid_out |-> !s_axi_arready_out)
    else $error("read address taken during answer");
  a_wr_answer: assert property (
    s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in &&
    s_axi_wready_out |-> ##2 s_axi_bvalid_out)
    else $error("write answer late");
  a_wr_busy: assert property (
    s_axi_bvalid_out |-> !s_axi_awready_out && !s_axi_wready_out)
    else $error("write taken during answer");
  a_res_clear: assert property (
    s_axi_arvalid_in && s_axi_arready_out &&
    s_axi_araddr_in == {IDX_RES_HI, 2'b00} |-> ##[1:2] !result_dma_req_out)
    else $error("result request not withdrawn");
  cover property ($rose(sample_out));
  cover property ($rose(result_dma_req_out));
  cover property ($rose(cmd_dma_req_out));
endmodule
bind adc_trigger_command_control adc_ctrl_chk chk_u (.*);

// File: bench/adc_far_model.sv
// far side: comparator on a held level and two reloading trigger timers
// assumes the bench sets the level and the design drives the trial code
`timescale 1ns/10ps
module adc_far_model #(
  parameter logic [23:0] PERIOD0 = 24'h000050,
  parameter logic [23:0] PERIOD1 = 24'h000070
) (
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  input wire logic [9:0] level_in,
  input wire logic [9:0] dac_code_in,
  output logic cmp_out,
  output logic trig0_out,
  output logic trig1_out
);
  logic [23:0] cnt0;
  logic [23:0] cnt1;
  assign cmp_out = level_in >= dac_code_in;
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cnt0 <= PERIOD0;
      cnt1 <= PERIOD1;
      trig0_out <= 1'b0;
      trig1_out <= 1'b0;
    end else begin
      trig0_out <= cnt0 == 24'h000000;
      trig1_out <= cnt1 == 24'h000000;
      cnt0 <= (cnt0 == 24'h000000) ? PERIOD0 : cnt0 - 24'h000001;
      cnt1 <= (cnt1 == 24'h000000) ? PERIOD1 : cnt1 - 24'h000001;
    end
  end
endmodule

// File: bench/tb_top.sv
// bench of the converter control: register master, triggers, checks
// assumes the far model drives comparator and timer lines
`timescale 1ns/10ps
module tb_top;
  import adc_ctrl_pkg::*;
  logic sys_clk_in, rst_b_in, s_axi_awvalid_in, s_axi_wvalid_in;
  logic s_axi_bready_in, s_axi_arvalid_in, s_axi_rready_in, cmp_in;
  logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out;
  logic s_axi_arready_out, s_axi_rvalid_out, sample_out, conv_irq_out;
  logic timer_trigger_line_0_in, timer_trigger_line_1_in;
  logic analog_enable_out, conv_clk_en_out;
  logic result_dma_req_out, cmd_dma_req_out;
  logic [6:0] s_axi_awaddr_in, s_axi_araddr_in;
  logic [31:0] s_axi_wdata_in, s_axi_rdata_out;
  logic [3:0] s_axi_wstrb_in, channel_sel_out, ch;
  logic [1:0] s_axi_bresp_out, s_axi_rresp_out;
  logic [15:0] an_pin_in;
  logic [9:0] dac_code_out, level;
  logic [33:0] expq [$];
  int error_cnt = 0;
  int checked = 0;
  int cyc = 0;
  int n;
  adc_trigger_command_control dut_u (.*);
  adc_far_model far_u (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in),
    .level_in(level), .dac_code_in(dac_code_out), .cmp_out(cmp_in),
    .trig0_out(timer_trigger_line_0_in), .trig1_out(timer_trigger_line_1_in));
  task automatic end_of_test();
    if (error_cnt == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(string nm, logic [33:0] e, logic [33:0] g);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wr(logic [4:0] i, logic [31:0] d);
    @(posedge sys_clk_in);
    s_axi_awaddr_in <= {i, 2'b00};
    s_axi_wdata_in <= d;
    s_axi_awvalid_in <= 1'b1;
    s_axi_wvalid_in <= 1'b1;
    s_axi_bready_in <= 1'b1;
    do begin
      @(posedge sys_clk_in);
      if (s_axi_awready_out) s_axi_awvalid_in <= 1'b0;
      if (s_axi_wready_out) s_axi_wvalid_in <= 1'b0;
    end while (!s_axi_bvalid_out);
    s_axi_bready_in <= 1'b0;
  endtask
  task automatic rd(logic [4:0] i, logic [33:0] e);
    @(posedge sys_clk_in);
    s_axi_araddr_in <= {i, 2'b00};
    s_axi_arvalid_in <= 1'b1;
    s_axi_rready_in <= 1'b1;
    expq.push_back(e);
    do @(posedge sys_clk_in); while (!s_axi_arready_out);
    s_axi_arvalid_in <= 1'b0;
    do @(posedge sys_clk_in); while (!s_axi_rvalid_out);
    s_axi_rready_in <= 1'b0;
  endtask
  task automatic run(logic [31:0] cw, logic [31:0] hi, logic r);
    wr(IDX_CW_HI, cw);
    do @(posedge sys_clk_in); while (!conv_irq_out);
    chk("chan", 34'(ch), 34'(channel_sel_out));
    chk("rdma", 34'(r), 34'(result_dma_req_out));
    rd(IDX_RES_LO, {RESP_OKAY, 22'h0, level});
    rd(IDX_RES_HI, {RESP_OKAY, hi});
    wr(IDX_FLAG, 32'h7);
    repeat (2) @(posedge sys_clk_in);
    chk("irq", 34'h0, 34'(conv_irq_out));
    chk("rdma", 34'h0, 34'(result_dma_req_out));
  endtask
  always @(posedge sys_clk_in)
    if (s_axi_rvalid_out && s_axi_rready_in)
      chk("read", expq.pop_front(), {s_axi_rresp_out, s_axi_rdata_out});
  initial begin
    sys_clk_in = 1'b0;
    forever #5 sys_clk_in = ~sys_clk_in;
  end
  always @(posedge sys_clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      end_of_test();
    end
  end
  initial begin
    {rst_b_in, s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in} = '0;
    {s_axi_arvalid_in, s_axi_rready_in, an_pin_in, level, ch} = '0;
    {s_axi_awaddr_in, s_axi_araddr_in, s_axi_wdata_in} = '0;
    s_axi_wstrb_in = 4'hf;
    void'($urandom(43378));
    repeat (20) @(posedge sys_clk_in);
    rst_b_in <= 1'b1;
    rd(IDX_MODE, {RESP_OKAY, 32'h1});
    rd(IDX_PRESCALE, {RESP_OKAY, 32'h4});
    rd(5'h04, {RESP_SLVERR, 32'h0});
    wr(IDX_INT, 32'h1);
    for (int i = 0; i < 4; i++) begin
      level = 10'($urandom);
      ch = 4'($urandom);
      wr(IDX_MODE, 32'(i[0]) << MODE_LEFT | 32'(i[1]) << MODE_RES_DMA |
        32'(i == 3) << MODE_SIGNED);
      @(posedge sys_clk_in);
      chk("en", 34'h1, 34'(analog_enable_out));
      run(32'(ch) | 32'h10 | 32'(i) << CW_STIME, 32'(level) << (6 * i[0])
        ^ 32'(i == 3) << 15, i[1]);
    end
    wr(IDX_MODE, 32'h4);
    repeat (2) @(posedge sys_clk_in);
    chk("cdma", 34'h1, 34'(cmd_dma_req_out));
    for (int s = 2; s < 4; s++) begin
      wr(IDX_TRIG_CTL, 32'(s));
      chk("cdma", 34'h0, 34'(cmd_dma_req_out));
      run(32'(ch) | 32'h30, 32'(level), 1'b0);
      chk("cdma", 34'h1, 34'(cmd_dma_req_out));
    end
    wr(IDX_MODE, 32'h0);
    wr(IDX_TRIG_CTL, 32'h1);
    wr(IDX_TRIG_CHAN, 32'h5);
    wr(IDX_CW_HI, 32'h35);
    @(posedge sys_clk_in);
    an_pin_in[5] <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk_in);
      n++;
    end while (!sample_out);
    chk("lat", 34'h4, 34'(n));
    an_pin_in[5] <= 1'b0;
    repeat (3) @(posedge sys_clk_in);
    an_pin_in[5] <= 1'b1;
    do @(posedge sys_clk_in); while (!conv_irq_out);
    rd(IDX_FLAG, {RESP_OKAY, 32'h3});
    wr(IDX_FLAG, 32'h7);
    wr(IDX_TRIG_CTL, 32'h5);
    wr(IDX_CW_HI, 32'h35);
    repeat (8) @(posedge sys_clk_in);
    an_pin_in[5] <= 1'b0;
    repeat (8) @(posedge sys_clk_in);
    rd(IDX_FLAG, {RESP_OKAY, 32'h4});
    end_of_test();
  end
endmodule
